// [include/pmc_pkg.sv]
package pmc_pkg;
  // Power modes held by the controller
  typedef enum logic [3:0] {
    M_RUN,
    M_WAIT,
    M_STOP,
    M_VERY_LOW_POWER_RUN,
    M_VERY_LOW_POWER_WAIT,
    M_VERY_LOW_POWER_STOP,
    M_LOW_LEAKAGE_STOP,
    M_LEAKAGE_STOP_LEVEL3,
    M_LEAKAGE_STOP_LEVEL1,
    M_LEAKAGE_STOP_LEVEL0
  } pmc_mode_e;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLK_GATE  = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;

  // Mode control fields
  localparam int         CTRL_VLP_RUN   = 0;
  localparam int         CTRL_DEEP      = 1;
  localparam int         CTRL_STOP_LSB  = 4;
  localparam int         CTRL_BOD_KEEP  = 8;
  localparam int         CTRL_EXT_CLK   = 9;
  localparam int         CTRL_IO_UNLOCK = 12;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_MASK     = 16'h0373;
  localparam logic [15:0] GATE_RESET    = 16'h0000;

  // Status fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_WAKEFLAG = 8;
  localparam int STAT_IO_HOLD  = 9;

  // Stop depth selection codes
  localparam logic [2:0] STOP_SEL_NORMAL      = 3'h0;
  localparam logic [2:0] STOP_SEL_LOW_LEAKAGE = 3'h1;
  localparam logic [2:0] STOP_SEL_LEVEL3      = 3'h2;
  localparam logic [2:0] STOP_SEL_LEVEL1      = 3'h3;
  localparam logic [2:0] STOP_SEL_LEVEL0      = 3'h4;

  // Wake source lines: pin, low power timer, real-time clock, oscillator, comparator
  localparam int         WAKE_W          = 5;
  localparam logic [4:0] WAKE_ALL        = 5'h1F;
  localparam logic [4:0] WAKE_LEVEL0_OK  = 5'h07;

  // Per-mode configuration vector positions
  localparam int CFG_W      = 14;
  localparam int CFG_LVD    = 0;
  localparam int CFG_LPO    = 1;
  localparam int CFG_BOD    = 2;
  localparam int CFG_REG_LP = 3;
  localparam int CFG_FREE_RUNNING_CORE_CLOCK   = 4;
  localparam int CFG_SYSCLK = 5;
  localparam int CFG_RAM    = 6;
  localparam int CFG_ASYNC  = 7;
  localparam int CFG_OSC    = 8;
  localparam int CFG_CMP    = 9;
  localparam int CFG_HOLD   = 10;
  localparam int CFG_NESTED_INTERRUPT_CONTROLLER   = 11;
  localparam int CFG_SLEEP  = 12;
  localparam int CFG_DEEP   = 13;

  // Clock rates and derived enable divisors
  localparam int CLK_HZ       = 10_000_000;
  localparam int FLASH_VLP_HZ = 1_000_000;
  localparam int CORE_VLP_HZ  = 4_000_000;
  localparam int BUS_MAX_HZ   = 800_000;
  localparam int FLASH_DIV    = CLK_HZ / FLASH_VLP_HZ;
  localparam int CORE_DIV     = (CLK_HZ + CORE_VLP_HZ - 1) / CORE_VLP_HZ;
  localparam int BUS_DIV      = CLK_HZ / BUS_MAX_HZ + 1;
endpackage

// [include/pmc_if.sv]
`timescale 1ns/10ps
interface pmc_if (
  input wire logic ref_clk_in,
  input wire logic rstn_in
);
  logic wfi_req;
  logic irq_pend;
  logic wake_ack;
  logic core_sleep;
  logic core_deep;
  logic nested_interrupt_controller_en;
  logic wake_flag;
  logic wake_rst;

  // Power controller end
  modport pmc (
    input  wfi_req,
    input  irq_pend,
    input  wake_ack,
    output core_sleep,
    output core_deep,
    output nested_interrupt_controller_en,
    output wake_flag,
    output wake_rst
  );

  // Processor core end
  modport core (
    output wfi_req,
    output irq_pend,
    output wake_ack,
    input  core_sleep,
    input  core_deep,
    input  nested_interrupt_controller_en,
    input  wake_flag,
    input  wake_rst
  );
endinterface

// [core/pmc_tick_div.sv]
`timescale 1ns/10ps
module pmc_tick_div #(
  parameter int DIV = 2
) (
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  input  wire logic en_in,
  output logic      tick_out
);
  logic [7:0] cnt_q;

  // Count down while enabled and pulse once per period
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q    <= 8'h00;
      tick_out <= 1'b0;
    end else if (!en_in) begin
      cnt_q    <= 8'h00;
      tick_out <= 1'b0;
    end else if (cnt_q == 8'h00) begin
      cnt_q    <= 8'(DIV - 1);
      tick_out <= 1'b1;
    end else begin
      cnt_q    <= cnt_q - 8'h01;
      tick_out <= 1'b0;
    end
  end
endmodule

// [core/pmc_core_end.sv]
`timescale 1ns/10ps
module pmc_core_end (
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  pmc_if.core       lnk,
  input  wire logic wfi_in,
  input  wire logic irq_in,
  input  wire logic wake_irq_mask_in,
  output logic [1:0] core_state_out,
  output logic       wake_isr_out,
  output logic       boot_out
);
  logic wfi_req_q;
  logic irq_pend_q;
  logic wake_ack_q;

  assign lnk.wfi_req  = wfi_req_q;
  assign lnk.irq_pend = irq_pend_q;
  assign lnk.wake_ack = wake_ack_q;

  // Issue one wait-for-interrupt pulse only while running
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wfi_req_q <= 1'b0;
    end else begin
      wfi_req_q <= wfi_in & ~lnk.core_sleep & ~lnk.core_deep & ~wfi_req_q;
    end
  end

  // Pending interrupt level seen by the controller
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_pend_q <= 1'b0;
    end else begin
      irq_pend_q <= irq_in;
    end
  end

  // Service the wake-up unit interrupt unless it is masked or the core is in deep sleep
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_ack_q   <= 1'b0;
      wake_isr_out <= 1'b0;
    end else begin
      wake_ack_q   <= lnk.wake_flag & ~wake_irq_mask_in & ~wake_ack_q & ~lnk.core_deep;
      wake_isr_out <= lnk.wake_flag & ~wake_irq_mask_in & ~wake_ack_q & ~lnk.core_deep;
    end
  end

  // Core state and reset-flow boot pulse
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_state_out <= 2'h0;
      boot_out       <= 1'b0;
    end else begin
      core_state_out <= {lnk.core_deep, lnk.core_sleep};
      boot_out       <= lnk.wake_rst;
    end
  end
endmodule

// [core/pmc_device.sv]
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
// What this block does
// - All clock gate bits clear on any reset
// - Software enables gate before using module
// - Software disables module before clearing gate
// - Pin states held in every wait and stop mode
// - Each run mode has wait and stop
// - Wait-for-interrupt enters wait or stop
// - Reset lands in normal run, regulator full
// - Normal wait: core sleeps, interrupts wake
// - Normal stop: retain, voltage detect, async wake
// - Low-power run: slow flash, reduced clocks
// - Low-power wait keeps core clock running
// - Low-power stop: static, async wake, RAM kept
// - Timer and UART need kept clock source
// - Low-leakage stop wakes via wake-up unit
// - Software keeps wake-up interrupt unmasked
// - Leakage level 3 keeps both RAMs
// - Leakage levels 1, 0 power RAMs off
// - Leakage stop wakes through reset flow
// - Level 0: oscillator off, brown-out optional
// - Level 0: only pin, timer, clock wake
module pmc_device (
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  pmc_if.pmc               lnk,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        async_wakeup_interrupt_ctrl_wake_in,
  input  wire logic [4:0]  wake_src_in,
  input  wire logic        async_clk_src_en_in,
  output logic [15:0]      periph_clk_en_out,
  output logic [3:0]       mode_out,
  output logic             lvd_en_out,
  output logic             lpo_en_out,
  output logic             bod_en_out,
  output logic             regulator_lp_out,
  output logic             free_running_core_clock_en_out,
  output logic             sys_clk_en_out,
  output logic [1:0]       ram_pwr_out,
  output logic             async_periph_en_out,
  output logic             osc_avail_out,
  output logic             cmp_avail_out,
  output logic             io_hold_out,
  output logic             flash_tick_out,
  output logic             core_tick_out,
  output logic             bus_tick_out
);
  pmc_pkg::pmc_mode_e mode_q;
  pmc_pkg::pmc_mode_e mode_d;
  logic [15:0]            ctrl_q;
  logic [15:0]            gate_q;
  logic                   wake_flag_q;
  logic                   wake_rst_q;
  logic                   io_hold_q;
  logic [pmc_pkg::CFG_W-1:0] cfg;
  logic [pmc_pkg::CFG_W-1:0] cfg_nx;
  logic                   wr_en;
  logic                   setup;
  logic                   vllx_wake;
  logic                   lls_wake;
  logic [4:0]             wake_ok;
  logic                   vlp;

  // Register select by byte offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // Per-mode settings of clocks, monitors and memories
  function automatic logic [pmc_pkg::CFG_W-1:0] mode_cfg(input pmc_pkg::pmc_mode_e m,
                                                         input logic bod_keep,
                                                         input logic async_src);
    logic [pmc_pkg::CFG_W-1:0] c;
    c = '0;
    c[pmc_pkg::CFG_LPO]  = 1'b1;
    c[pmc_pkg::CFG_BOD]  = 1'b1;
    c[pmc_pkg::CFG_RAM]  = 1'b1;
    c[pmc_pkg::CFG_OSC]  = 1'b1;
    c[pmc_pkg::CFG_CMP]  = 1'b1;
    c[pmc_pkg::CFG_HOLD] = 1'b1;
    case (m)
      pmc_pkg::M_RUN: begin
        c[pmc_pkg::CFG_LVD]    = 1'b1;
        c[pmc_pkg::CFG_FREE_RUNNING_CORE_CLOCK]   = 1'b1;
        c[pmc_pkg::CFG_SYSCLK] = 1'b1;
        c[pmc_pkg::CFG_NESTED_INTERRUPT_CONTROLLER]   = 1'b1;
        c[pmc_pkg::CFG_HOLD]   = 1'b0;
      end
      pmc_pkg::M_WAIT: begin
        c[pmc_pkg::CFG_LVD]    = 1'b1;
        c[pmc_pkg::CFG_FREE_RUNNING_CORE_CLOCK]   = 1'b1;
        c[pmc_pkg::CFG_SYSCLK] = 1'b1;
        c[pmc_pkg::CFG_NESTED_INTERRUPT_CONTROLLER]   = 1'b1;
        c[pmc_pkg::CFG_SLEEP]  = 1'b1;
      end
      pmc_pkg::M_STOP: begin
        c[pmc_pkg::CFG_LVD]  = 1'b1;
        c[pmc_pkg::CFG_DEEP] = 1'b1;
      end
      pmc_pkg::M_VERY_LOW_POWER_RUN: begin
        c[pmc_pkg::CFG_REG_LP] = 1'b1;
        c[pmc_pkg::CFG_FREE_RUNNING_CORE_CLOCK]   = 1'b1;
        c[pmc_pkg::CFG_SYSCLK] = 1'b1;
        c[pmc_pkg::CFG_NESTED_INTERRUPT_CONTROLLER]   = 1'b1;
        c[pmc_pkg::CFG_HOLD]   = 1'b0;
      end
      pmc_pkg::M_VERY_LOW_POWER_WAIT: begin
        c[pmc_pkg::CFG_REG_LP] = 1'b1;
        c[pmc_pkg::CFG_FREE_RUNNING_CORE_CLOCK]   = 1'b1;
        c[pmc_pkg::CFG_SYSCLK] = 1'b1;
        c[pmc_pkg::CFG_NESTED_INTERRUPT_CONTROLLER]   = 1'b1;
        c[pmc_pkg::CFG_SLEEP]  = 1'b1;
      end
      pmc_pkg::M_VERY_LOW_POWER_STOP: begin
        c[pmc_pkg::CFG_REG_LP] = 1'b1;
        c[pmc_pkg::CFG_DEEP]   = 1'b1;
        c[pmc_pkg::CFG_ASYNC]  = async_src;
      end
      pmc_pkg::M_LOW_LEAKAGE_STOP, pmc_pkg::M_LEAKAGE_STOP_LEVEL3: begin
        c[pmc_pkg::CFG_REG_LP] = 1'b1;
        c[pmc_pkg::CFG_DEEP]   = 1'b1;
      end
      pmc_pkg::M_LEAKAGE_STOP_LEVEL1: begin
        c[pmc_pkg::CFG_RAM]  = 1'b0;
        c[pmc_pkg::CFG_DEEP] = 1'b1;
      end
      pmc_pkg::M_LEAKAGE_STOP_LEVEL0: begin
        c[pmc_pkg::CFG_RAM]  = 1'b0;
        c[pmc_pkg::CFG_DEEP] = 1'b1;
        c[pmc_pkg::CFG_LPO]  = 1'b0;
        c[pmc_pkg::CFG_BOD]  = bod_keep;
        c[pmc_pkg::CFG_OSC]  = 1'b0;
        c[pmc_pkg::CFG_CMP]  = 1'b0;
      end
      default: begin
        c = '0;
      end
    endcase
    mode_cfg = c;
  endfunction

  assign cfg   = mode_cfg(mode_q, ctrl_q[pmc_pkg::CTRL_BOD_KEEP], async_clk_src_en_in);
  assign cfg_nx = mode_cfg(mode_d, 1'b0, 1'b0);
  assign setup = psel_in & ~penable_in;
  assign wr_en = psel_in & penable_in & pready_out & pwrite_in;
  assign vlp   = (mode_q == pmc_pkg::M_VERY_LOW_POWER_RUN);

  // Wake sources allowed by leakage depth
  assign wake_ok   = (mode_q == pmc_pkg::M_LEAKAGE_STOP_LEVEL0) ?
                     (wake_src_in & pmc_pkg::WAKE_LEVEL0_OK) : (wake_src_in & pmc_pkg::WAKE_ALL);
  assign lls_wake  = (mode_q == pmc_pkg::M_LOW_LEAKAGE_STOP) & (|wake_ok);
  assign vllx_wake = ((mode_q == pmc_pkg::M_LEAKAGE_STOP_LEVEL3) |
                      (mode_q == pmc_pkg::M_LEAKAGE_STOP_LEVEL1) |
                      (mode_q == pmc_pkg::M_LEAKAGE_STOP_LEVEL0)) & (|wake_ok);

  // Next mode: entry on wait-for-interrupt, recovery per mode
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      pmc_pkg::M_RUN, pmc_pkg::M_VERY_LOW_POWER_RUN: begin
        if (lnk.wfi_req) begin
          if (!ctrl_q[pmc_pkg::CTRL_DEEP]) begin
            mode_d = vlp ? pmc_pkg::M_VERY_LOW_POWER_WAIT : pmc_pkg::M_WAIT;
          end else begin
            case (ctrl_q[pmc_pkg::CTRL_STOP_LSB +: 3])
              pmc_pkg::STOP_SEL_LOW_LEAKAGE: mode_d = pmc_pkg::M_LOW_LEAKAGE_STOP;
              pmc_pkg::STOP_SEL_LEVEL3:      mode_d = pmc_pkg::M_LEAKAGE_STOP_LEVEL3;
              pmc_pkg::STOP_SEL_LEVEL1:      mode_d = pmc_pkg::M_LEAKAGE_STOP_LEVEL1;
              pmc_pkg::STOP_SEL_LEVEL0:      mode_d = pmc_pkg::M_LEAKAGE_STOP_LEVEL0;
              default:                       mode_d = vlp ? pmc_pkg::M_VERY_LOW_POWER_STOP : pmc_pkg::M_STOP;
            endcase
          end
        end else if (ctrl_q[pmc_pkg::CTRL_VLP_RUN] != vlp) begin
          mode_d = vlp ? pmc_pkg::M_RUN : pmc_pkg::M_VERY_LOW_POWER_RUN;
        end
      end
      pmc_pkg::M_WAIT: begin
        if (lnk.irq_pend) begin
          mode_d = pmc_pkg::M_RUN;
        end
      end
      pmc_pkg::M_VERY_LOW_POWER_WAIT: begin
        if (lnk.irq_pend) begin
          mode_d = pmc_pkg::M_VERY_LOW_POWER_RUN;
        end
      end
      pmc_pkg::M_STOP: begin
        if (async_wakeup_interrupt_ctrl_wake_in) begin
          mode_d = pmc_pkg::M_RUN;
        end
      end
      pmc_pkg::M_VERY_LOW_POWER_STOP: begin
        if (async_wakeup_interrupt_ctrl_wake_in) begin
          mode_d = pmc_pkg::M_VERY_LOW_POWER_RUN;
        end
      end
      default: begin
        if (lls_wake | vllx_wake) begin
          mode_d = pmc_pkg::M_RUN;
        end
      end
    endcase
  end

  // Mode state register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_q <= pmc_pkg::M_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Control register; the reset flow of leakage wake clears it
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= pmc_pkg::CTRL_RESET;
    end else if (vllx_wake) begin
      ctrl_q <= pmc_pkg::CTRL_RESET;
    end else if (wr_en && hit(paddr_in, pmc_pkg::OFF_MODE_CTRL)) begin
      ctrl_q <= pwdata_in[15:0] & pmc_pkg::CTRL_MASK;
    end
  end

  // Clock gate enables, cleared by every reset
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gate_q <= pmc_pkg::GATE_RESET;
    end else if (vllx_wake) begin
      gate_q <= pmc_pkg::GATE_RESET;
    end else if (wr_en && hit(paddr_in, pmc_pkg::OFF_CLK_GATE)) begin
      gate_q <= pwdata_in[15:0];
    end
  end

  // Wake-up unit flag: set on leakage wake, cleared by core or software
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_flag_q <= 1'b0;
    end else if (lls_wake | vllx_wake) begin
      wake_flag_q <= 1'b1;
    end else if (lnk.wake_ack ||
                 (wr_en && hit(paddr_in, pmc_pkg::OFF_STATUS) && pwdata_in[pmc_pkg::STAT_WAKEFLAG])) begin
      wake_flag_q <= 1'b0;
    end
  end

  // Reset-flow pulse and pin hold kept after leakage recovery until unlocked
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_rst_q <= 1'b0;
      io_hold_q  <= 1'b0;
    end else begin
      wake_rst_q <= vllx_wake;
      if (vllx_wake) begin
        io_hold_q <= 1'b1;
      end else if (wr_en && hit(paddr_in, pmc_pkg::OFF_MODE_CTRL) && pwdata_in[pmc_pkg::CTRL_IO_UNLOCK]) begin
        io_hold_q <= 1'b0;
      end
    end
  end

  // APB slave: answer one cycle after setup, error on unmapped offset
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup & ~(hit(paddr_in, pmc_pkg::OFF_MODE_CTRL) |
                               hit(paddr_in, pmc_pkg::OFF_CLK_GATE) | hit(paddr_in, pmc_pkg::OFF_STATUS));
      prdata_out  <= 32'h0000_0000;
      if (setup && hit(paddr_in, pmc_pkg::OFF_MODE_CTRL)) begin
        prdata_out <= {16'h0000, ctrl_q};
      end else if (setup && hit(paddr_in, pmc_pkg::OFF_CLK_GATE)) begin
        prdata_out <= {16'h0000, gate_q};
      end else if (setup && hit(paddr_in, pmc_pkg::OFF_STATUS)) begin
        prdata_out <= {22'h000000, io_hold_q, wake_flag_q, 4'h0, mode_q};
      end
    end
  end

  // Registered power outputs
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      periph_clk_en_out   <= 16'h0000;
      mode_out            <= 4'h0;
      lvd_en_out          <= 1'b1;
      lpo_en_out          <= 1'b1;
      bod_en_out          <= 1'b1;
      regulator_lp_out    <= 1'b0;
      free_running_core_clock_en_out         <= 1'b1;
      sys_clk_en_out      <= 1'b1;
      ram_pwr_out         <= 2'h3;
      async_periph_en_out <= 1'b0;
      osc_avail_out       <= 1'b1;
      cmp_avail_out       <= 1'b1;
      io_hold_out         <= 1'b0;
    end else begin
      periph_clk_en_out   <= gate_q & {16{cfg[pmc_pkg::CFG_SYSCLK]}};
      mode_out            <= mode_q;
      lvd_en_out          <= cfg[pmc_pkg::CFG_LVD];
      lpo_en_out          <= cfg[pmc_pkg::CFG_LPO];
      bod_en_out          <= cfg[pmc_pkg::CFG_BOD];
      regulator_lp_out    <= cfg[pmc_pkg::CFG_REG_LP];
      free_running_core_clock_en_out         <= cfg[pmc_pkg::CFG_FREE_RUNNING_CORE_CLOCK];
      sys_clk_en_out      <= cfg[pmc_pkg::CFG_SYSCLK];
      ram_pwr_out         <= {2{cfg[pmc_pkg::CFG_RAM]}};
      async_periph_en_out <= cfg[pmc_pkg::CFG_ASYNC];
      osc_avail_out       <= cfg[pmc_pkg::CFG_OSC];
      cmp_avail_out       <= cfg[pmc_pkg::CFG_CMP];
      io_hold_out         <= cfg[pmc_pkg::CFG_HOLD] | io_hold_q;
    end
  end

  // Core-facing link signals
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lnk.core_sleep <= 1'b0;
      lnk.core_deep  <= 1'b0;
      lnk.nested_interrupt_controller_en    <= 1'b1;
    end else begin
      lnk.core_sleep <= cfg_nx[pmc_pkg::CFG_SLEEP];
      lnk.core_deep  <= cfg_nx[pmc_pkg::CFG_DEEP];
      lnk.nested_interrupt_controller_en    <= cfg_nx[pmc_pkg::CFG_NESTED_INTERRUPT_CONTROLLER];
    end
  end
  assign lnk.wake_flag = wake_flag_q;
  assign lnk.wake_rst  = wake_rst_q;

  // Reduced-rate enables used in low-power run and wait
  pmc_tick_div #(.DIV(pmc_pkg::FLASH_DIV)) u_flash_div (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .en_in      (cfg[pmc_pkg::CFG_REG_LP] & cfg[pmc_pkg::CFG_SYSCLK]),
    .tick_out   (flash_tick_out)
  );
  pmc_tick_div #(.DIV(pmc_pkg::CORE_DIV)) u_core_div (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .en_in      (cfg[pmc_pkg::CFG_REG_LP] & cfg[pmc_pkg::CFG_FREE_RUNNING_CORE_CLOCK] & ~ctrl_q[pmc_pkg::CTRL_EXT_CLK]),
    .tick_out   (core_tick_out)
  );
  pmc_tick_div #(.DIV(pmc_pkg::BUS_DIV)) u_bus_div (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .en_in      (cfg[pmc_pkg::CFG_REG_LP] & cfg[pmc_pkg::CFG_SYSCLK] & ~ctrl_q[pmc_pkg::CTRL_EXT_CLK]),
    .tick_out   (bus_tick_out)
  );
endmodule

// [bench/pmc_checker.sv]
`timescale 1ns/10ps
module pmc_checker (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic wfi_req,
  input wire logic irq_pend,
  input wire logic wake_ack,
  input wire logic core_sleep,
  input wire logic core_deep,
  input wire logic nested_interrupt_controller_en,
  input wire logic wake_flag,
  input wire logic wake_rst
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // Link relations between controller and core
  a_wfi_enters_low: assert property (wfi_req && !core_sleep && !core_deep |=> core_sleep || core_deep)
    else $error("wfi did not enter a low power mode");
  a_sleep_deep_excl: assert property (!(core_sleep && core_deep))
    else $error("sleep and deep sleep together");
  a_sleep_nested_interrupt_controller_on: assert property (core_sleep |-> nested_interrupt_controller_en)
    else $error("interrupt controller off in wait");
  a_deep_nested_interrupt_controller_off: assert property (core_deep |-> !nested_interrupt_controller_en)
    else $error("interrupt controller on in stop");
  a_irq_wakes_wait: assert property (core_sleep && irq_pend |=> !core_sleep)
    else $error("interrupt did not end wait");
  a_wake_rst_pulse: assert property (wake_rst |=> !wake_rst)
    else $error("wake reset longer than one cycle");
  a_wake_rst_flag: assert property (wake_rst |-> wake_flag)
    else $error("wake reset without wake flag");
  a_rst_after_deep: assert property ($rose(wake_rst) |-> $past(core_deep, 2))
    else $error("wake reset not after deep sleep");
  a_ack_clears_flag: assert property (wake_ack && !core_deep |=> !wake_flag)
    else $error("wake flag kept after ack");
  // Main scenarios reached
  c_wait: cover property (core_sleep && irq_pend);
  c_deep: cover property (core_deep);
  c_wake_rst: cover property (wake_rst);
  c_ack: cover property (wake_ack);
endmodule

// [bench/pmc_tb.sv]
`timescale 1ns/10ps
module power_mode_controller_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        async_wakeup_interrupt_ctrl = 1'b0, asrc = 1'b0, wait_for_interrupt_instr = 1'b0, irq = 1'b0, mask = 1'b0;
  logic [4:0]  wsrc = 5'h00;
  logic [15:0] pce;
  logic [3:0]  mode;
  logic [1:0]  ram, cst;
  logic        low_voltage_detect, low_power_oscillator_1khz, reglp, free_running_core_clock, aper, osc, ioh, ft, ct, bt, bod, cmp;
  int          miscompares = 0, comparisons = 0, nf, nc, nb;
  // Clock and link
  always #50 clk = ~clk;
  pmc_if i_pmc_if (.ref_clk_in(clk), .rstn_in(rstn));
  pmc_device i_pmc_device (.ref_clk_in(clk), .rstn_in(rstn), .lnk(i_pmc_if), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .async_wakeup_interrupt_ctrl_wake_in(async_wakeup_interrupt_ctrl), .wake_src_in(wsrc), .async_clk_src_en_in(asrc),
    .periph_clk_en_out(pce), .mode_out(mode), .lvd_en_out(low_voltage_detect), .lpo_en_out(low_power_oscillator_1khz), .bod_en_out(bod),
    .regulator_lp_out(reglp), .free_running_core_clock_en_out(free_running_core_clock), .sys_clk_en_out(), .ram_pwr_out(ram),
    .async_periph_en_out(aper), .osc_avail_out(osc), .cmp_avail_out(cmp), .io_hold_out(ioh),
    .flash_tick_out(ft), .core_tick_out(ct), .bus_tick_out(bt));
  pmc_core_end i_pmc_core_end (.ref_clk_in(clk), .rstn_in(rstn), .lnk(i_pmc_if), .wfi_in(wait_for_interrupt_instr), .irq_in(irq),
    .wake_irq_mask_in(mask), .core_state_out(cst), .wake_isr_out(), .boot_out());
  pmc_checker i_pmc_checker (.ref_clk_in(clk), .rstn_in(rstn), .wfi_req(i_pmc_if.wfi_req),
    .irq_pend(i_pmc_if.irq_pend), .wake_ack(i_pmc_if.wake_ack), .core_sleep(i_pmc_if.core_sleep),
    .core_deep(i_pmc_if.core_deep), .nested_interrupt_controller_en(i_pmc_if.nested_interrupt_controller_en), .wake_flag(i_pmc_if.wake_flag),
    .wake_rst(i_pmc_if.wake_rst));
  // Comparison and bus helpers
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic sleep_pulse();
    @(posedge clk);
    wait_for_interrupt_instr <= 1'b1;
    @(posedge clk);
    wait_for_interrupt_instr <= 1'b0;
    wt(4);
  endtask
  task automatic pulse_irq();
    irq <= 1'b1;
    wt(4);
    irq <= 1'b0;
    wt(2);
  endtask
  task automatic pulse_async_wakeup_interrupt_ctrl();
    async_wakeup_interrupt_ctrl <= 1'b1;
    wt(4);
    async_wakeup_interrupt_ctrl <= 1'b0;
    wt(2);
  endtask
  // Reset state, bus refusal and clock gates
  task automatic t_reset();
    chk("mode", mode, 4'h0);
    chk("reg_lp", reglp, 1'b0);
    apb(1'b0, pmc_pkg::OFF_CLK_GATE, 32'h0);
    chk("gates", rd, 32'h0);
    apb(1'b1, 8'h0C, 32'h0000FFFF);
    chk("slverr", pslverr, 1'b1);
    apb(1'b1, pmc_pkg::OFF_CLK_GATE, 32'h000000A5);
    apb(1'b0, pmc_pkg::OFF_CLK_GATE, 32'h0);
    chk("gates", rd, 32'h000000A5);
    chk("pce", pce, 16'h00A5);
  endtask
  // Normal wait and normal stop
  task automatic t_wait_stop();
    sleep_pulse();
    chk("mode", mode, 4'h1);
    chk("core", cst, 2'h1);
    chk("pce", pce, 16'h00A5);
    chk("hold", ioh, 1'b1);
    pulse_irq();
    chk("mode", mode, 4'h0);
    apb(1'b1, pmc_pkg::OFF_MODE_CTRL, 32'h00000002);
    sleep_pulse();
    chk("mode", mode, 4'h2);
    chk("pce", pce, 16'h0000);
    chk("lvd", low_voltage_detect, 1'b1);
    chk("core", cst, 2'h2);
    pulse_async_wakeup_interrupt_ctrl();
    chk("mode", mode, 4'h0);
  endtask
  // Very low power run, wait and stop
  task automatic t_vlp();
    apb(1'b1, pmc_pkg::OFF_MODE_CTRL, 32'h00000001);
    wt(3);
    chk("mode", mode, 4'h3);
    chk("lvd", low_voltage_detect, 1'b0);
    chk("reg_lp", reglp, 1'b1);
    {nf, nc, nb} = '0;
    repeat (390) @(posedge clk) begin
      nf += int'(ft);
      nc += int'(ct);
      nb += int'(bt);
    end
    chk("ticks", {nf[7:0], nc[7:0], nb[7:0]}, {8'd39, 8'd130, 8'd30});
    sleep_pulse();
    chk("mode", mode, 4'h4);
    chk("free_running_core_clock", free_running_core_clock, 1'b1);
    pulse_irq();
    chk("mode", mode, 4'h3);
    apb(1'b1, pmc_pkg::OFF_MODE_CTRL, 32'h00000003);
    asrc <= 1'b1;
    sleep_pulse();
    chk("mode", mode, 4'h5);
    chk("free_running_core_clock", free_running_core_clock, 1'b0);
    chk("ram", ram, 2'h3);
    chk("async", aper, 1'b1);
    asrc <= 1'b0;
    wt(3);
    chk("async", aper, 1'b0);
    pulse_async_wakeup_interrupt_ctrl();
    chk("mode", mode, 4'h3);
    apb(1'b1, pmc_pkg::OFF_MODE_CTRL, 32'h00000000);
    wt(3);
  endtask
  // Every leakage stop depth, entry and wake
  task automatic t_leak();
    for (int s = 1; s <= 4; s++) begin
      apb(1'b1, pmc_pkg::OFF_MODE_CTRL, 32'h2 | (s << 4));
      sleep_pulse();
      chk("mode", mode, 5 + s);
      chk("ram", ram, (s >= 3) ? 2'h0 : 2'h3);
      chk("lpo", low_power_oscillator_1khz, s != 4);
      chk("osc", osc, s != 4);
      chk("cmp", cmp, s != 4);
      chk("bod", bod, s != 4);
      if (s == 4) begin
        wsrc <= 5'h08;
        wt(4);
        chk("mode", mode, 4'h9);
      end
      wsrc <= 5'h01;
      wt(2);
      wsrc <= 5'h00;
      wt(10);
      chk("mode", mode, 4'h0);
      chk("hold", ioh, s > 1);
      apb(1'b0, pmc_pkg::OFF_STATUS, 32'h0);
      chk("flag", rd[8], 1'b0);
      apb(1'b1, pmc_pkg::OFF_MODE_CTRL, 32'h00001000);
      wt(2);
      chk("hold", ioh, 1'b0);
    end
    mask <= 1'b1;
    apb(1'b1, pmc_pkg::OFF_MODE_CTRL, 32'h00000012);
    sleep_pulse();
    wsrc <= 5'h01;
    wt(2);
    wsrc <= 5'h00;
    wt(10);
    apb(1'b0, pmc_pkg::OFF_STATUS, 32'h0);
    chk("flag", rd[8], 1'b1);
    apb(1'b1, pmc_pkg::OFF_STATUS, 32'h00000100);
    apb(1'b0, pmc_pkg::OFF_STATUS, 32'h0);
    chk("flag", rd[8], 1'b0);
    mask <= 1'b0;
  endtask
  // Verdict
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    wt(4);
    rstn <= 1'b1;
    wt(1);
    t_reset();
    t_wait_stop();
    t_vlp();
    t_leak();
    give_verdict();
  end
  // Watchdog
  initial begin
    wt(20000);
    miscompares++;
    give_verdict();
  end
endmodule
